// file: core/tap_port.sv
/*
 * tap_port: boundary-scan test access port of a memory device, with the
 * controller, instruction, bypass, identification and boundary registers,
 * and a crossing that hands a newly loaded instruction to system logic if no earlier one is pending.
 * Assumes rst_n is the power-up reset; the test clock may stand still.
 */
// How it works
// R01 - standard sixteen-state controller and serial registers
// R02 - inputs on rising, outputs on falling edge
// R03 - mode select sampled each rising edge
// R04 - undriven mode select reads as one
// R05 - data in shifts into selected register
// R06 - undriven data in reads as one
// R07 - path chosen by state and instruction
// R08 - output drives selected bit, updates falling
// R09 - no separate test reset pin exists
// R10 - five high mode-select edges reach reset
// R11 - controller resets itself at power-up
// R12 - idle and harmless until clocked after reset
// R13 - 3-bit instruction, preset to identification
// R14 - capture loads 01 into low bits
// R15 - bypass is one single-bit register
// R16 - 32-bit identification, bit 0 first out
// R17 - output high impedance outside shift states
// R18 - state advances per rising edge and mode
`timescale 1ns/10ps
module tap_port
  import tap_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               tck,
  input  wire logic               tms_pin,
  input  wire logic               tms_drv,
  input  wire logic               tdi_pin,
  input  wire logic               tdi_drv,
  input  wire logic [BSR_LEN-1:0] pins_in,
  output logic                    tdo,
  output logic                    tdo_oe,
  output logic      [BSR_LEN-1:0] bsr_drive,
  output logic                    extest_on,
  output logic                    hiz_force,
  output logic                    instr_valid,
  output logic      [IR_WIDTH-1:0] instr_code,
  input  wire logic               instr_ready
);

  // test-clock rising-edge state
  typedef struct packed {
    tap_state_e          st;
    instr_t              ir;
    instr_t              ir_sh;
    logic                byp;
    logic [ID_WIDTH-1:0] id;
    logic [BSR_LEN-1:0]  bsr;
    logic [BSR_LEN-1:0]  pins_m;
    logic [BSR_LEN-1:0]  pins_s;
    logic                req;
    instr_t              req_word;
    logic                ack_m;
    logic                ack_s;
  } tck_s;

  // test-clock falling-edge state
  typedef struct packed {
    logic               tdo;
    logic               oe;
    logic [BSR_LEN-1:0] bsr_upd;
    logic               ext;
    logic               hiz;
  } out_s;

  // system-clock state
  typedef struct packed {
    logic req_m;
    logic req_s;
    logic ack;
  } sys_s;

  tck_s t_q;
  tck_s t_d;
  out_s o_q;
  out_s o_d;
  sys_s s_q;
  sys_s s_d;

  logic   tms_eff;
  logic   tdi_eff;
  logic   ser;
  logic   push;
  logic   fifo_in_ready;

  // pull-ups on the test inputs: a floating pin reads as one
  assign tms_eff = tms_drv ? tms_pin : 1'b1; // R04
  assign tdi_eff = tdi_drv ? tdi_pin : 1'b1; // R06

  // serial bit at the output end of whichever register is in the path
  always_comb begin
    ser = 1'b0;
    if (t_q.st == SHIFT_IR) begin
      ser = t_q.ir_sh[0];
    end else if (t_q.st == SHIFT_DR) begin
      if (t_q.ir == INS_IDCODE) begin // R07
        ser = t_q.id[0]; // R16
      end else if (uses_bsr(t_q.ir)) begin
        ser = t_q.bsr[0];
      end else begin
        ser = t_q.byp; // R15
      end
    end
  end

  // controller and serial registers, all on the rising test-clock edge
  always_comb begin
    t_d       = t_q;
    t_d.st    = tap_next(t_q.st, tms_eff); // R01 R03 R10 R18
    t_d.ack_m = s_q.ack;
    t_d.ack_s = t_q.ack_m;
    // memory pins belong to another clock: two flops before capture reads
    t_d.pins_m = pins_in;
    t_d.pins_s = t_q.pins_m;
    case (t_q.st)
      TAP_RESET: begin
        t_d.ir  = INS_IDCODE; // R13
      end
      CAP_IR: begin
        t_d.ir_sh = {IR_CAPTURE_MSB, IR_CAPTURE_PAT}; // R14
      end
      SHIFT_IR: begin
        t_d.ir_sh = {tdi_eff, t_q.ir_sh[IR_WIDTH-1:1]}; // R05
      end
      UPD_IR: begin
        t_d.ir  = t_q.ir_sh;
        // a new word is offered only if the previous one is taken; otherwise it is dropped
        if (t_q.req == t_q.ack_s) begin
          t_d.req      = ~t_q.req;
          t_d.req_word = t_q.ir_sh;
        end
      end
      CAP_DR: begin
        t_d.byp = 1'b0;
        if (t_q.ir == INS_IDCODE) begin
          t_d.id = ID_CODE_RST; // R16
        end
        if (uses_bsr(t_q.ir)) begin
          t_d.bsr = t_q.pins_s;
        end
      end
      SHIFT_DR: begin
        if (t_q.ir == INS_IDCODE) begin // R07
          t_d.id = {tdi_eff, t_q.id[ID_WIDTH-1:1]}; // R05
        end else if (uses_bsr(t_q.ir)) begin
          t_d.bsr = {tdi_eff, t_q.bsr[BSR_LEN-1:1]};
        end else begin
          t_d.byp = tdi_eff; // R15
        end
      end
      default: begin
      end
    endcase
  end

  // power-up reset only; there is no separate test reset input
  always_ff @(posedge tck or negedge rst_n) begin // R02
    if (!rst_n) begin // R09 R11
      t_q          <= '0;
      t_q.st       <= TAP_RESET;
      t_q.ir       <= INS_IDCODE; // R13
      t_q.id       <= ID_CODE_RST;
    end else begin
      t_q <= t_d;
    end
  end

  // output launched on the falling edge, driven only while shifting;
  // update stages move on the same edge, half way through their state
  always_comb begin
    o_d     = o_q;
    o_d.tdo = ser; // R08
    o_d.oe  = is_shift(t_q.st); // R17
    case (t_q.st)
      TAP_RESET: begin
        o_d.ext = 1'b0;
        o_d.hiz = 1'b0;
      end
      UPD_IR: begin
        o_d.ext = (t_q.ir_sh == INS_EXTEST); // R02
        o_d.hiz = (t_q.ir_sh == INS_SAMPLE_Z);
      end
      UPD_DR: begin
        if (uses_bsr(t_q.ir)) begin
          o_d.bsr_upd = t_q.bsr; // R02
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(negedge tck or negedge rst_n) begin // R02
    if (!rst_n) begin
      o_q <= '0; // R12
    end else begin
      o_q <= o_d;
    end
  end

  // system side: two-flop sync of the request toggle, then push and ack
  assign push = (s_q.req_s != s_q.ack) && fifo_in_ready;

  always_comb begin
    s_d       = s_q;
    s_d.req_m = t_q.req;
    s_d.req_s = s_q.req_m;
    if (push) begin
      s_d.ack = ~s_q.ack;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // the word is held by the test side until the ack returns
  word_fifo #(
    .WIDTH (IR_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_data   (t_q.req_word),
    .in_ready  (fifo_in_ready),
    .out_valid (instr_valid),
    .out_data  (instr_code),
    .out_ready (instr_ready)
  );

  assign tdo       = o_q.tdo;
  assign tdo_oe    = o_q.oe;
  assign bsr_drive = o_q.bsr_upd;
  assign extest_on = o_q.ext;
  assign hiz_force = o_q.hiz;

  // checks on the test-clock side, then one on the system clock
  sequence s_idle_go_dr;
    (t_q.st == RUN_IDLE) && tms_eff;
  endsequence

  sequence s_enter_shift;
    !tms_eff ##1 !tms_eff;
  endsequence

  a_five_high_reset: assert property ( // R10
    @(posedge tck) disable iff (!rst_n)
    tms_eff [*5] |=> (t_q.st == TAP_RESET))
    else $error("five high mode-select edges did not reset");

  a_walk_to_shift: assert property ( // R18
    @(posedge tck) disable iff (!rst_n)
    s_idle_go_dr ##1 s_enter_shift |=> (t_q.st == SHIFT_DR))
    else $error("idle to shift walk went wrong");

  a_floating_tms: assert property ( // R04
    @(posedge tck) disable iff (!rst_n)
    ((t_q.st == RUN_IDLE) && !tms_drv) |=> (t_q.st == SEL_DR))
    else $error("undriven mode select not seen as one");

  a_tdo_hiz_state: assert property ( // R17
    @(posedge tck) disable iff (!rst_n)
    tdo_oe == is_shift(t_q.st))
    else $error("output enable does not match shift state");

  a_tdo_data_bit: assert property ( // R08
    @(posedge tck) disable iff (!rst_n)
    tdo_oe |-> (tdo == ser))
    else $error("scan output not the selected bit");

  a_ir_preset_id: assert property ( // R13
    @(posedge tck) disable iff (!rst_n)
    (t_q.st == TAP_RESET) |=> (t_q.ir == INS_IDCODE))
    else $error("instruction not preset in reset state");

  a_ir_capture_pat: assert property ( // R14
    @(posedge tck) disable iff (!rst_n)
    (t_q.st == CAP_IR) |=> (t_q.ir_sh[1:0] == IR_CAPTURE_PAT))
    else $error("capture pattern wrong");

  a_id_capture: assert property ( // R16
    @(posedge tck) disable iff (!rst_n)
    ((t_q.st == CAP_DR) && (t_q.ir == INS_IDCODE))
      |=> (t_q.id == ID_CODE_RST))
    else $error("identification word not captured");

  a_bypass_one_bit: assert property ( // R15
    @(posedge tck) disable iff (!rst_n)
    ((t_q.st == SHIFT_DR) && (t_q.ir == INS_BYPASS))
      |=> (t_q.byp == $past(tdi_eff)))
    else $error("bypass did not take the data bit");

  a_ir_shift_in: assert property ( // R05
    @(posedge tck) disable iff (!rst_n)
    (t_q.st == SHIFT_IR) |=> (t_q.ir_sh[IR_WIDTH-1] == $past(tdi_eff)))
    else $error("instruction shifter lost the data bit");

  a_push_acked: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    push |=> (s_q.ack == s_q.req_s))
    else $error("pushed word not acknowledged");

endmodule : tap_port

// file: core/word_fifo.sv
/*
 * word_fifo: small shifting buffer with valid/ready on both sides.
 * Entry 0 is always the head, so the read side sees flops directly.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/10ps
module word_fifo
  import tap_pkg::*;
#(
  parameter int WIDTH = IR_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  typedef struct packed {
    logic [DEPTH-1:0]            vld;
    logic [DEPTH-1:0][WIDTH-1:0] mem;
  } fifo_s;

  fifo_s q;
  fifo_s d;

  // pop shifts everything down, then a push fills the first free slot
  always_comb begin
    logic found;
    found = 1'b0;
    d = q;
    if (out_ready && q.vld[0]) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        d.mem[i] = q.mem[i+1];
        d.vld[i] = q.vld[i+1];
      end
      d.vld[DEPTH-1] = 1'b0;
    end
    if (in_valid && in_ready) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!found && !d.vld[i]) begin
          d.mem[i] = in_data;
          d.vld[i] = 1'b1;
          found    = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // full is judged before the pop, trading a cycle for a short path
  assign in_ready  = !q.vld[DEPTH-1];
  assign out_valid = q.vld[0];
  assign out_data  = q.mem[0];

  a_fifo_full_stall: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ((&q.vld) && !out_ready) |=> ((&q.vld) && $stable(q.mem)))
    else $error("stalled full buffer lost or changed a word");

  a_fifo_head_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
    else $error("stalled head word changed");

endmodule : word_fifo

// file: shared/tap_pkg.sv
/*
 * tap_pkg: constants, state enum and decode helpers for the boundary-scan
 * test access port. Assumes a 3-bit instruction register, a 32-bit
 * identification register and a short boundary register.
 */
package tap_pkg;

  // widths of the serial registers, buffer depth and reset edge count
  localparam int IR_WIDTH        = 3;
  localparam int ID_WIDTH        = 32;
  localparam int BSR_LEN         = 8;
  localparam int FIFO_DEPTH      = 2;
  localparam int RESET_TMS_EDGES = 5;

  typedef logic [IR_WIDTH-1:0] instr_t;

  // instruction codes; all zeros is the external test
  localparam instr_t INS_EXTEST   = 3'h0;
  localparam instr_t INS_IDCODE   = 3'h1;
  localparam instr_t INS_SAMPLE_Z = 3'h2;
  localparam instr_t INS_SAMPLE   = 3'h4;
  localparam instr_t INS_BYPASS   = 3'h7;

  // capture pattern of the instruction shifter, upper bit and low pair
  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
  localparam logic       IR_CAPTURE_MSB = 1'b0;

  // identification word; value is arbitrary, bit 0 set as required
  localparam logic [ID_WIDTH-1:0] ID_CODE_RST = 32'h1234_5ACF;

  // sixteen controller states
  typedef enum logic [3:0] {
    TAP_RESET, RUN_IDLE,
    SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } tap_state_e;

  // next state from the sampled mode-select level
  function automatic tap_state_e tap_next(input tap_state_e st,
                                          input logic tms);
    case (st)
      TAP_RESET: tap_next = tms ? TAP_RESET : RUN_IDLE;
      RUN_IDLE:  tap_next = tms ? SEL_DR    : RUN_IDLE;
      SEL_DR:    tap_next = tms ? SEL_IR    : CAP_DR;
      CAP_DR:    tap_next = tms ? EXIT1_DR  : SHIFT_DR;
      SHIFT_DR:  tap_next = tms ? EXIT1_DR  : SHIFT_DR;
      EXIT1_DR:  tap_next = tms ? UPD_DR    : PAUSE_DR;
      PAUSE_DR:  tap_next = tms ? EXIT2_DR  : PAUSE_DR;
      EXIT2_DR:  tap_next = tms ? UPD_DR    : SHIFT_DR;
      UPD_DR:    tap_next = tms ? SEL_DR    : RUN_IDLE;
      SEL_IR:    tap_next = tms ? TAP_RESET : CAP_IR;
      CAP_IR:    tap_next = tms ? EXIT1_IR  : SHIFT_IR;
      SHIFT_IR:  tap_next = tms ? EXIT1_IR  : SHIFT_IR;
      EXIT1_IR:  tap_next = tms ? UPD_IR    : PAUSE_IR;
      PAUSE_IR:  tap_next = tms ? EXIT2_IR  : PAUSE_IR;
      EXIT2_IR:  tap_next = tms ? UPD_IR    : SHIFT_IR;
      UPD_IR:    tap_next = tms ? SEL_DR    : RUN_IDLE;
      default:   tap_next = TAP_RESET;
    endcase
  endfunction : tap_next

  // instructions that place the boundary register in the path
  function automatic logic uses_bsr(input instr_t ir);
    uses_bsr = (ir == INS_EXTEST) || (ir == INS_SAMPLE) ||
               (ir == INS_SAMPLE_Z);
  endfunction : uses_bsr

  // states in which the scan output drives
  function automatic logic is_shift(input tap_state_e st);
    is_shift = (st == SHIFT_DR) || (st == SHIFT_IR);
  endfunction : is_shift

endpackage : tap_pkg

// file: verif/scan_master.sv
/*
 * scan_master: behavioural scan controller that clocks the test port one
 * bit at a time. Assumes the bench never overlaps two bit_cycle calls;
 * the test clock stands low between calls, as a real controller's may.
 */
`timescale 1ns/10ps
module scan_master (
  output logic tck,
  output logic tms_pin,
  output logic tms_drv,
  output logic tdi_pin,
  output logic tdi_drv
);
  // pins idle released until the first bit
  initial begin
    tck     = 1'b0;
    tms_pin = 1'b0;
    tms_drv = 1'b0;
    tdi_pin = 1'b0;
    tdi_drv = 1'b0;
  end

  // one 32 ns test clock; inputs move just after the low edge so that
  // they are long settled at the sampling high edge
  task automatic bit_cycle(input logic tms, input logic tdi,
                           input logic tms_en, input logic tdi_en);
    #2;
    tms_drv = tms_en;
    tdi_drv = tdi_en;
    // a released pin shows the inverse of its pulled level, so only the
    // port's own pull-up handling can make it read as one
    tms_pin = tms_en ? tms : 1'b0;
    tdi_pin = tdi_en ? tdi : 1'b0;
    #14 tck = 1'b1;
    #16 tck = 1'b0;
  endtask : bit_cycle
endmodule : scan_master

// file: verif/tb_top.sv
/*
 * tb_top: self-checking bench of the test access port. The scan master
 * clocks the link; queues hold expected scan bits and handed-off words.
 * Assumes the port's notes: bit 0 first out, capture-IR pattern 001.
 */
`timescale 1ns/10ps
module tb_top;
  import tap_pkg::*;
  logic                clk_sys;
  logic                rst_n;
  logic                tck;
  logic                tms_pin;
  logic                tms_drv;
  logic                tdi_pin;
  logic                tdi_drv;
  logic [BSR_LEN-1:0]  pins_in;
  logic                tdo;
  logic                tdo_oe;
  logic [BSR_LEN-1:0]  bsr_drive;
  logic                extest_on;
  logic                hiz_force;
  logic                instr_valid;
  logic [IR_WIDTH-1:0] instr_code;
  logic                instr_ready;
  logic                stall;
  logic                tdi_float;
  logic                exp_tdo[$];
  instr_t              exp_instr[$];
  int                  n_mismatch;
  int                  samples_checked;

  tap_port tap_port_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms_pin(tms_pin),
    .tms_drv(tms_drv), .tdi_pin(tdi_pin), .tdi_drv(tdi_drv),
    .pins_in(pins_in), .tdo(tdo), .tdo_oe(tdo_oe), .bsr_drive(bsr_drive),
    .extest_on(extest_on), .hiz_force(hiz_force),
    .instr_valid(instr_valid), .instr_code(instr_code),
    .instr_ready(instr_ready)
  );

  scan_master scan_master_inst (
    .tck(tck), .tms_pin(tms_pin), .tms_drv(tms_drv),
    .tdi_pin(tdi_pin), .tdi_drv(tdi_drv)
  );

  // system clock, 50 ns
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic tbit(input logic tms, input logic tdi);
    scan_master_inst.bit_cycle(tms, tdi, 1'b1, !tdi_float);
  endtask : tbit

  // five high edges with the mode pin released, then to idle
  task automatic goto_reset();
    repeat (RESET_TMS_EDGES)
      scan_master_inst.bit_cycle(1'b1, 1'b0, 1'b0, 1'b1);
    tbit(1'b0, 1'b0);
  endtask : goto_reset

  // idle -> capture -> shift n bits -> update -> idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      input logic [63:0] dexp);
    // leave idle on the released mode pin: only its pull-up reads one
    scan_master_inst.bit_cycle(1'b1, 1'b0, 1'b0, !tdi_float);
    if (ir)
      tbit(1'b1, 1'b0);
    tbit(1'b0, 1'b0);
    tbit(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      exp_tdo.push_back(dexp[i]);
      tbit(i == n - 1, din[i]);
    end
    tbit(1'b1, 1'b0);
    tbit(1'b0, 1'b0);
  endtask : scan

  task automatic wait_drain();
    for (int i = 0; i < 400 && exp_instr.size() != 0; i++)
      @(posedge clk_sys);
    check(32'(exp_instr.size()), 32'h0, "words left");
  endtask : wait_drain

  // scan output is looked at on every high edge while it drives
  always @(posedge tck) begin
    if (tdo_oe === 1'b1) begin
      if (exp_tdo.size() == 0)
        check(tdo_oe, 1'b0, "unexpected drive");
      else
        check(tdo, exp_tdo.pop_front(), "scan out");
    end
  end

  // handed-off words; an empty queue turns any word into a mismatch
  always @(posedge clk_sys) begin
    if (instr_valid === 1'b1 && instr_ready === 1'b1) begin
      if (exp_instr.size() == 0)
        check(instr_valid, 1'b0, "extra word");
      else
        check(instr_code, exp_instr.pop_front(), "word");
    end
  end

  // consumer: random acceptance unless stalled
  always @(posedge clk_sys) begin
    #2;
    instr_ready = stall ? 1'b0 : 1'($urandom_range(1));
  end

  initial begin
    #400000;
    n_mismatch++;
    $display("MISMATCH at %0t: watchdog ran out", $time);
    conclude();
  end

  initial begin : main
    instr_t      codes[6];
    logic [63:0] pat;
    codes = '{INS_EXTEST, INS_SAMPLE_Z, INS_SAMPLE, INS_IDCODE,
              INS_BYPASS, 3'h3};
    void'($urandom(32'hB799ABC7));
    rst_n = 1'b0;
    stall = 1'b1;
    tdi_float = 1'b0;
    pins_in = 8'h00;
    repeat (20) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    repeat (10) @(posedge clk_sys);
    // quiet until clocked
    check(tdo_oe, 1'b0, "oe idle");
    check(instr_valid, 1'b0, "valid idle");
    check({extest_on, hiz_force, bsr_drive}, 32'h0, "outputs idle");
    // identification read straight after power-up, then tdi comes through
    tbit(1'b0, 1'b0);
    pat = {$urandom, $urandom};
    scan(1'b0, 40, pat, {pat[7:0], ID_CODE_RST});
    for (int k = 0; k < 6; k++) begin
      if (k == 3) begin
        check(instr_valid, 1'b1, "full buffer holds");
        stall = 1'b0;
        wait_drain();
      end
      exp_instr.push_back(codes[k]);
      scan(1'b1, 3, 64'(codes[k]), 64'h1);
      check(extest_on, codes[k] == INS_EXTEST, "extest flag");
      check(hiz_force, codes[k] == INS_SAMPLE_Z, "hiz flag");
      @(posedge clk_sys);
      #2 pins_in = 8'($urandom);
      pat = {$urandom, $urandom};
      tdi_float = (k == 5);
      if (tdi_float)
        pat = '1;
      if (uses_bsr(codes[k])) begin
        scan(1'b0, 8, pat, 64'(pins_in));
        check(bsr_drive, pat[7:0], "boundary update");
      end else if (codes[k] == INS_IDCODE)
        scan(1'b0, 32, pat, 64'(ID_CODE_RST));
      else
        scan(1'b0, 9, pat, {pat[7:0], 1'b0});
      if (k >= 3)
        wait_drain();
    end
    // reset from the middle of a bypass shift, then id is back
    tdi_float = 1'b0;
    tbit(1'b1, 1'b0);
    tbit(1'b0, 1'b0);
    tbit(1'b0, 1'b0);
    exp_tdo.push_back(1'b0);
    goto_reset();
    scan(1'b0, 32, 64'h0, 64'(ID_CODE_RST));
    repeat (20) @(posedge clk_sys);
    check(32'(exp_tdo.size()), 32'h0, "scan bits left");
    check(32'(exp_instr.size()), 32'h0, "words left");
    conclude();
  end
endmodule : tb_top
